/* aec_top.sv */
/*
  correctable mask, error control and header log register bank of one
  switch port, reached over an avalon-mm slave with waitrequest.
  assumes events, status and headers come from logic on core_clk_in.
*/
// Our own choice: the Avalon-MM register port.
// What this block does
// [R01] a set receiver, bad packet or bad link packet mask stops that event's report.
// [R02] a set replay rollover, replay timeout or advisory mask stops that event's report.
// [R03] the advisory mask resets to one, other masks to zero, all are sticky read-write.
// [R04] the single bit mask reads zero and has no effect while its report enable is low.
// [R05] a masked single bit error is neither logged, nor pointed to, nor reported.
// [R06] the single bit mask never stops the single bit status from setting.
// [R07] a five-bit sticky read-only pointer holds the first reported error's position.
// [R08] generation capable sits at bit 5, resets to one, and is written only when unlocked.
// [R09] check capable sits at bit 7, resets to one, and is written only when unlocked.
// [R10] sticky generation enable at bit 6 turns on crc append for sent packets while generation capable is one.
// [R11] sticky check enable at bit 8 turns on crc checking of received packets while check capable is one.
// [R12] the first three header words of the first reported error are captured read-only.
// [R13] the fourth header word of that error is captured at the next offset.
// [R14] each status bit is set by its event and cleared only by writing one.
// [R15] reserved bits of mask and control read zero and ignore writes.
// [R16] sticky fields and the header log survive hot reset, only full reset clears them.
`timescale 1ns/1ns
module aec_top
  import aec_pkg::*;
(
  input  wire logic         core_clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         hot_rst_n_in,
  input  wire logic [11:0]  avs_address_in,
  input  wire logic         avs_read_in,
  input  wire logic         avs_write_in,
  input  wire logic [31:0]  avs_writedata_in,
  input  wire logic [3:0]   avs_byteenable_in,
  output logic      [31:0]  avs_readdata_out,
  output logic              avs_waitrequest_out,
  input  wire logic [6:0]   cor_event_in,
  input  wire logic         single_bit_report_enable_in,
  input  wire logic         unlock_in,
  input  wire logic         unc_report_in,
  input  wire logic [4:0]   unc_bit_pos_in,
  input  wire logic [31:0]  unc_status_in,
  input  wire logic [127:0] unc_header_in,
  output logic              cor_report_out,
  output logic              crc_gen_enable_out,
  output logic              crc_check_enable_out,
  output logic              irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // event vector order: rcv, bad pkt, bad link, rollover, timeout, advisory, single bit
  function automatic logic [31:0] ev_to_bits(input logic [6:0] ev);
    logic [31:0] b;
    b                = 32'h0000_0000;
    b[BIT_RCV_ERR]   = ev[0];
    b[BIT_BAD_PKT]   = ev[1];
    b[BIT_BAD_LINK]  = ev[2];
    b[BIT_RPLY_ROLL] = ev[3];
    b[BIT_RPLY_TO]   = ev[4];
    b[BIT_ADVISORY]  = ev[5];
    b[BIT_SGL_BIT]   = ev[6];
    ev_to_bits = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  aec_log_if lg ();

  aec_bus_state_type bus_state_r;
  logic              wait_r;
  logic [31:0]       rdata_r;
  logic [31:0]       rd_value;
  logic              wr_fire;
  logic [31:0]       wmask;
  logic [31:0]       cor_status_r;
  logic [31:0]       cor_mask_r;
  logic [31:0]       ev_bits;
  logic [31:0]       ev_report;
  logic              gen_cap_r;
  logic              chk_cap_r;
  logic              gen_en_r;
  logic              chk_en_r;
  logic [1:0]        irq_status_r;
  logic [1:0]        irq_mask_r;
  logic [1:0]        irq_set;
  logic              cor_report_r;
  logic              gen_out_r;
  logic              chk_out_r;
  logic              irq_r;

  assign avs_waitrequest_out  = wait_r;
  assign avs_readdata_out     = rdata_r;
  assign cor_report_out       = cor_report_r;
  assign crc_gen_enable_out   = gen_out_r;
  assign crc_check_enable_out = chk_out_r;
  assign irq_out              = irq_r;

  assign lg.unc_report  = unc_report_in;
  assign lg.unc_bit_pos = unc_bit_pos_in;
  assign lg.unc_status  = unc_status_in;
  assign lg.unc_header  = unc_header_in;
  assign lg.rd_idx      = 2'(avs_address_in[5:2] - HDR_IDX_BASE); // [R13]

  aec_first_err u_first_err (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .lg          (lg.trk)
  );

  aec_hdr_log u_hdr_log (
    .core_clk_in (core_clk_in),
    .rst_n_in    (rst_n_in),
    .lg          (lg.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: two wait cycles, the header memory needs one to read

  assign wr_fire = (bus_state_r == BUS_DONE) && avs_write_in;
  assign wmask   = be_mask(avs_byteenable_in);

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !hot_rst_n_in)
    begin
      bus_state_r <= BUS_IDLE;
      wait_r      <= 1'b1;
      rdata_r     <= 32'h0000_0000;
    end
    else
    begin
      unique case (bus_state_r)
        BUS_IDLE:
        begin
          if (avs_read_in || avs_write_in)
            bus_state_r <= BUS_FETCH;
        end
        BUS_FETCH:
        begin
          bus_state_r <= BUS_DONE;
          wait_r      <= 1'b0;
          rdata_r     <= avs_read_in ? rd_value : 32'h0000_0000;
        end
        BUS_DONE:
        begin
          bus_state_r <= BUS_IDLE;
          wait_r      <= 1'b1;
        end
        default:
        begin
          bus_state_r <= BUS_IDLE;
          wait_r      <= 1'b1;
        end
      endcase
    end
  end

  // unmapped addresses read zero
  always_comb
  begin
    rd_value = 32'h0000_0000;
    case (avs_address_in)
      ADDR_COR_STATUS:
        rd_value = {cor_status_r[31] & single_bit_report_enable_in, cor_status_r[30:0]};
      ADDR_COR_MASK:
        // gated here too, the stored bit drops one edge after the enable
        rd_value = cor_mask_r & COR_IMPL_BITS
                 & {single_bit_report_enable_in, 31'h7FFF_FFFF}; // [R04] [R15]
      ADDR_ERR_CTL:
      begin
        rd_value[CTL_PTR_LSB +: 5] = lg.first_ptr; // [R07]
        rd_value[CTL_GEN_CAP]      = gen_cap_r;
        rd_value[CTL_GEN_EN]       = gen_en_r;
        rd_value[CTL_CHK_CAP]      = chk_cap_r;
        rd_value[CTL_CHK_EN]       = chk_en_r;
      end
      ADDR_HDR_LOG0, ADDR_HDR_LOG1, ADDR_HDR_LOG2, ADDR_HDR_LOG3:
        rd_value = lg.rd_data; // [R12] [R13]
      ADDR_IRQ_STATUS:
        rd_value = {30'h0000_0000, irq_status_r};
      ADDR_IRQ_MASK:
        rd_value = {30'h0000_0000, irq_mask_r};
      default:
        rd_value = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // correctable status and mask

  // single bit status stays quiet while its report enable is low
  assign ev_bits   = ev_to_bits(cor_event_in)
                   & {single_bit_report_enable_in, 31'h7FFF_FFFF}; // [R06]
  assign ev_report = ev_bits & ~cor_mask_r; // [R01] [R02] [R05]

  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      cor_status_r <= COR_STAT_RST; // [R16]
    else if (wr_fire && avs_address_in == ADDR_COR_STATUS)
      cor_status_r <= (cor_status_r & ~(avs_writedata_in & wmask & COR_IMPL_BITS))
                    | ev_bits; // [R14]
    else
      cor_status_r <= cor_status_r | ev_bits; // [R14]
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      cor_mask_r <= COR_MASK_RST; // [R03]
    else if (wr_fire && avs_address_in == ADDR_COR_MASK)
      cor_mask_r <= ((cor_mask_r & ~wmask) | (avs_writedata_in & wmask))
                  & COR_IMPL_BITS
                  & {single_bit_report_enable_in, 31'h7FFF_FFFF}; // [R03] [R04] [R15]
    else if (!single_bit_report_enable_in)
      // stored bit dropped too, so re-enabling never revives a stale mask
      cor_mask_r <= cor_mask_r & COR_IMPL_BITS & 32'h7FFF_FFFF; // [R04]
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !hot_rst_n_in)
      cor_report_r <= 1'b0;
    else
      cor_report_r <= |ev_report; // [R01] [R02] [R05]
  end

  ////////////////////////////////////////////////////////////////////////////
  // error control

  // capable bits are not sticky: hot reset restores them
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !hot_rst_n_in)
    begin
      gen_cap_r <= CTL_CAP_RST;
      chk_cap_r <= CTL_CAP_RST;
    end
    else if (wr_fire && avs_address_in == ADDR_ERR_CTL && unlock_in)
    begin
      if (avs_byteenable_in[0])
        gen_cap_r <= avs_writedata_in[CTL_GEN_CAP]; // [R08]
      if (avs_byteenable_in[0])
        chk_cap_r <= avs_writedata_in[CTL_CHK_CAP]; // [R09]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      gen_en_r <= CTL_EN_RST; // [R16]
      chk_en_r <= CTL_EN_RST;
    end
    else if (wr_fire && avs_address_in == ADDR_ERR_CTL)
    begin
      if (avs_byteenable_in[0])
        gen_en_r <= avs_writedata_in[CTL_GEN_EN]; // [R10]
      if (avs_byteenable_in[1])
        chk_en_r <= avs_writedata_in[CTL_CHK_EN]; // [R11]
    end
  end

  // an enable without its capability would promise what the port cannot do
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      gen_out_r <= 1'b0;
      chk_out_r <= 1'b0;
    end
    else
    begin
      gen_out_r <= gen_en_r & gen_cap_r; // [R10]
      chk_out_r <= chk_en_r & chk_cap_r; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts

  assign irq_set = {lg.cap_we, |ev_report};

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !hot_rst_n_in)
      irq_status_r <= IRQ_RST;
    else if (wr_fire && avs_address_in == ADDR_IRQ_STATUS && avs_byteenable_in[0])
      irq_status_r <= (irq_status_r & ~avs_writedata_in[1:0]) | irq_set;
    else
      irq_status_r <= irq_status_r | irq_set;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !hot_rst_n_in)
      irq_mask_r <= IRQ_RST;
    else if (wr_fire && avs_address_in == ADDR_IRQ_MASK && avs_byteenable_in[0])
      irq_mask_r <= avs_writedata_in[1:0];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in || !hot_rst_n_in)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_status_r & irq_mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_rcv_masked: assert property ( // [R01]
    (cor_event_in == 7'h01 && cor_mask_r[BIT_RCV_ERR]) |=> !cor_report_out)
    else $error("masked receiver error was reported");

  a_rcv_reported: assert property ( // [R01]
    (cor_event_in == 7'h01 && !cor_mask_r[BIT_RCV_ERR] && hot_rst_n_in)
      |=> cor_report_out ##1 cor_status_r[BIT_RCV_ERR])
    else $error("unmasked receiver error not reported");

  a_timeout_masked: assert property ( // [R02]
    (cor_event_in == 7'h10 && cor_mask_r[BIT_RPLY_TO]) |=> !cor_report_out)
    else $error("masked replay timeout was reported");

  a_mask_reset: assert property ( // [R03]
    $rose(rst_n_in) |-> cor_mask_r == COR_MASK_RST)
    else $error("mask register reset value wrong");

  a_sbe_read_zero: assert property ( // [R04]
    (bus_state_r == BUS_FETCH && avs_read_in && avs_address_in == ADDR_COR_MASK
      && !single_bit_report_enable_in && hot_rst_n_in) |=> !avs_readdata_out[31])
    else $error("single bit mask not read as zero");

  a_sbe_masked: assert property ( // [R05]
    (cor_event_in == 7'h40 && cor_mask_r[BIT_SGL_BIT]) |=> !cor_report_out)
    else $error("masked single bit error was reported");

  a_sbe_status: assert property ( // [R06]
    (cor_event_in[6] && single_bit_report_enable_in) |=> cor_status_r[BIT_SGL_BIT])
    else $error("single bit status failed to set");

  a_ptr_frozen: assert property ( // [R07]
    (lg.log_valid && unc_report_in) |=> $stable(lg.first_ptr))
    else $error("first error pointer overwritten");

  a_cap_locked: assert property ( // [R08]
    (wr_fire && avs_address_in == ADDR_ERR_CTL && !unlock_in && hot_rst_n_in)
      |=> $stable(gen_cap_r) && $stable(chk_cap_r))
    else $error("locked capable bit changed");

  a_gen_enable: assert property ( // [R10]
    (wr_fire && avs_address_in == ADDR_ERR_CTL && avs_byteenable_in[0]
      && avs_writedata_in[CTL_GEN_EN] && gen_cap_r && hot_rst_n_in
      && (avs_writedata_in[CTL_GEN_CAP] || !unlock_in))
      |=> ##1 crc_gen_enable_out)
    else $error("generation enable did not reach its output");

  a_chk_enable: assert property ( // [R11]
    (wr_fire && avs_address_in == ADDR_ERR_CTL && avs_byteenable_in[1]
      && !avs_writedata_in[CTL_CHK_EN]) |=> ##1 !crc_check_enable_out)
    else $error("check enable did not clear its output");

  a_hdr_capture: assert property ( // [R07]
    lg.cap_we |=> lg.log_valid && lg.first_ptr == $past(unc_bit_pos_in))
    else $error("first error capture missed");

  a_status_held: assert property ( // [R14]
    (cor_status_r[BIT_RCV_ERR]
      && !(wr_fire && avs_address_in == ADDR_COR_STATUS
           && avs_writedata_in[BIT_RCV_ERR] && avs_byteenable_in[0]))
      |=> cor_status_r[BIT_RCV_ERR])
    else $error("status bit cleared without write of one");

  a_mask_reserved: assert property ( // [R15]
    (cor_mask_r & ~COR_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved mask bit set");

  a_hot_keeps: assert property ( // [R16]
    (!hot_rst_n_in && !wr_fire) |=> $stable(cor_mask_r[30:0]))
    else $error("hot reset disturbed sticky mask");

  c_report:  cover property (cor_report_out);
  c_capture: cover property (lg.cap_we ##[1:20] lg.cap_we);
  c_ctl_wr:  cover property (wr_fire && avs_address_in == ADDR_ERR_CTL);
  c_irq:     cover property (irq_out);

endmodule

/* aec_pkg.sv */
/*
  constants for the correctable mask, error control and header log bank.
  assumes byte addresses on a 32-bit register bus, one word per register.
*/
package aec_pkg;

  // register byte addresses
  localparam logic [11:0] ADDR_COR_STATUS = 12'h110;
  localparam logic [11:0] ADDR_COR_MASK   = 12'h114;
  localparam logic [11:0] ADDR_ERR_CTL    = 12'h118;
  localparam logic [11:0] ADDR_HDR_LOG0   = 12'h11C;
  localparam logic [11:0] ADDR_HDR_LOG1   = 12'h120;
  localparam logic [11:0] ADDR_HDR_LOG2   = 12'h124;
  localparam logic [11:0] ADDR_HDR_LOG3   = 12'h128;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h130;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h134;
  // word index of the first header log word, low four bits
  localparam logic [3:0]  HDR_IDX_BASE    = 4'h7;
  localparam int          HDR_WORDS       = 4;

  // correctable event bit positions
  localparam int BIT_RCV_ERR   = 0;
  localparam int BIT_BAD_PKT   = 6;
  localparam int BIT_BAD_LINK  = 7;
  localparam int BIT_RPLY_ROLL = 8;
  localparam int BIT_RPLY_TO   = 12;
  localparam int BIT_ADVISORY  = 13;
  localparam int BIT_SGL_BIT   = 31;

  // implemented correctable bits, mask reset value
  localparam logic [31:0] COR_IMPL_BITS = 32'h8000_31C1;
  localparam logic [31:0] COR_MASK_RST  = 32'h0000_2000;
  localparam logic [31:0] COR_STAT_RST  = 32'h0000_0000;

  // error control field positions and reset values
  localparam int   CTL_PTR_LSB   = 0;
  localparam int   CTL_GEN_CAP   = 5;
  localparam int   CTL_GEN_EN    = 6;
  localparam int   CTL_CHK_CAP   = 7;
  localparam int   CTL_CHK_EN    = 8;
  localparam logic CTL_CAP_RST   = 1'h1;
  localparam logic CTL_EN_RST    = 1'h0;
  localparam logic [4:0] PTR_RST = 5'h00;

  // interrupt status bits
  localparam int         IRQ_COR_REPORT = 0;
  localparam int         IRQ_HDR_CAPT   = 1;
  localparam logic [1:0] IRQ_RST        = 2'h0;

  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_FETCH = 2'b01,
    BUS_DONE  = 2'b10
  } aec_bus_state_type;

endpackage

/* aec_log_if.sv */
/*
  interface between the bank top, the first error tracker and the header log.
  assumes all three sit on one clock.
*/
`timescale 1ns/1ns
interface aec_log_if;
  logic         unc_report;
  logic [4:0]   unc_bit_pos;
  logic [31:0]  unc_status;
  logic [127:0] unc_header;
  logic         cap_we;
  logic [4:0]   first_ptr;
  logic         log_valid;
  logic [1:0]   rd_idx;
  logic [31:0]  rd_data;

  modport top (output unc_report, unc_bit_pos, unc_status, unc_header, rd_idx,
               input  cap_we, first_ptr, log_valid, rd_data);
  modport trk (input  unc_report, unc_bit_pos, unc_status,
               output cap_we, first_ptr, log_valid);
  modport mem (input  cap_we, unc_header, rd_idx,
               output rd_data);
endinterface

/* aec_first_err.sv */
/*
  first error tracker: holds the pointer of the first reported uncorrectable
  error. assumes the uncorrectable status already shows the pointed bit.
*/
`timescale 1ns/1ns
module aec_first_err
  import aec_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  aec_log_if.trk    lg
);

  logic       valid_r;
  logic [4:0] ptr_r;

  assign lg.cap_we    = lg.unc_report & ~valid_r; // [R12]
  assign lg.log_valid = valid_r;
  assign lg.first_ptr = ptr_r;

  // only a full reset clears it, hot reset leaves it alone
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      valid_r <= 1'b0;
      ptr_r   <= PTR_RST; // [R16]
    end
    else if (lg.cap_we)
    begin
      valid_r <= 1'b1;
      ptr_r   <= lg.unc_bit_pos; // [R07]
    end
    else if (valid_r && !lg.unc_status[ptr_r])
    begin
      // re-arm once software cleared the pointed status bit
      valid_r <= 1'b0;
    end
  end

endmodule

/* aec_hdr_log.sv */
/*
  header log memory: four words written together, one word read out
  through a register. assumes capture and read on the same clock.
*/
`timescale 1ns/1ns
module aec_hdr_log
  import aec_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  aec_log_if.mem    lg
);

  logic [31:0] word_r [HDR_WORDS];
  logic [31:0] rd_data_r;

  assign lg.rd_data = rd_data_r;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < HDR_WORDS; i++)
        word_r[i] <= 32'h0000_0000; // [R16]
    end
    else if (lg.cap_we)
    begin
      for (int i = 0; i < HDR_WORDS; i++)
        word_r[i] <= lg.unc_header[i*32 +: 32]; // [R12] [R13]
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      rd_data_r <= 32'h0000_0000;
    else
      rd_data_r <= word_r[lg.rd_idx];
  end

endmodule

/* aec_rc_model.sv */
/*
  root complex side model: counts correctable reports and keeps the
  uncorrectable status that the first error pointer refers to.
  assumes one clock with the bank and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module aec_rc_model
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cor_report_in,
  input  wire logic        unc_report_in,
  input  wire logic [4:0]  unc_bit_pos_in,
  input  wire logic        unc_clear_in,
  output logic      [31:0] unc_status_out,
  output logic      [15:0] n_report_out
);
  always_ff @(posedge core_clk_in)
    if (!rst_n_in)
      n_report_out <= 16'h0000;
    else if (cor_report_in)
      n_report_out <= n_report_out + 16'h0001;

  // status shows the pointed bit from the cycle after the report
  always_ff @(posedge core_clk_in)
    if (!rst_n_in || unc_clear_in)
      unc_status_out <= 32'h0000_0000;
    else if (unc_report_in)
      unc_status_out[unc_bit_pos_in] <= 1'b1;
endmodule

/* aec_top_tb_top.sv */
/*
  testbench of the correctable mask, control and header log bank.
  assumes the avalon timing and capture behaviour of the bank's note.
*/
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module aec_top_tb_top
  import aec_pkg::*;
;
  localparam logic [127:0] HDR_A = 128'h4444_0004_3333_0003_2222_0002_1111_0001;
  logic        clk, rst_n, hot_n, rd, wr, sbe_en, unlock, unc_rep, clr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [6:0]  ev;
  logic [3:0]  be;
  logic [4:0]  pos;
  logic [127:0] hdr;
  logic [31:0] rdata, unc_stat;
  logic        wait_r, rep, gen_en, chk_en, irq;
  logic [15:0] n_rep;
  int          n_mismatch;
  int          checked;
  int          i;

  aec_top aec_top_i (.core_clk_in(clk), .rst_n_in(rst_n), .hot_rst_n_in(hot_n),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_r), .cor_event_in(ev),
    .single_bit_report_enable_in(sbe_en), .unlock_in(unlock),
    .unc_report_in(unc_rep), .unc_bit_pos_in(pos), .unc_status_in(unc_stat),
    .unc_header_in(hdr), .cor_report_out(rep), .crc_gen_enable_out(gen_en),
    .crc_check_enable_out(chk_en), .irq_out(irq));

  aec_rc_model aec_rc_model_i (.core_clk_in(clk), .rst_n_in(rst_n),
    .cor_report_in(rep), .unc_report_in(unc_rep), .unc_bit_pos_in(pos),
    .unc_clear_in(clr), .unc_status_out(unc_stat), .n_report_out(n_rep));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (wait_r === 1'b0)
        break;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 20)
    begin
      n_mismatch++;
      $display("unexpected at %0t: bus access hung", $time);
      end_of_test();
    end
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0000_0000, q);
    `CHK(q, exp)
  endtask

  // result of the event is visible just after the second edge
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= 7'h00;
    #1;
  endtask

  task automatic unc(input logic [4:0] p, input logic [127:0] h);
    @(posedge clk);
    unc_rep <= 1'b1;
    pos <= p;
    hdr <= h;
    @(posedge clk);
    unc_rep <= 1'b0;
  endtask

  task automatic hot_reset;
    @(posedge clk);
    hot_n <= 1'b0;
    @(posedge clk);
    hot_n <= 1'b1;
    @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0; hot_n = 1'b1; rd = 1'b0; wr = 1'b0; sbe_en = 1'b0;
    unlock = 1'b0; unc_rep = 1'b0; clr = 1'b0; addr = 12'h000;
    wdata = 32'h0; ev = 7'h00; pos = 5'h00; hdr = 128'h0; be = 4'hF;
    n_mismatch = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_COR_MASK, COR_MASK_RST);
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A0);
    rd_chk(ADDR_HDR_LOG2, 32'h0000_0000);
    rd_chk(ADDR_COR_STATUS, COR_STAT_RST);
    $display("test reset_values done");

    wr32(ADDR_COR_MASK, 32'hFFFF_FFFF);
    rd_chk(ADDR_COR_MASK, 32'h0000_31C1);
    wr32(ADDR_ERR_CTL, 32'hFFFF_FFFF);
    rd_chk(ADDR_ERR_CTL, 32'h0000_01E0);
    `CHK(gen_en, 1'b1)
    `CHK(chk_en, 1'b1)
    unlock <= 1'b1;
    wr32(ADDR_ERR_CTL, 32'h0000_0140);
    rd_chk(ADDR_ERR_CTL, 32'h0000_0140);
    `CHK(gen_en, 1'b0)
    `CHK(chk_en, 1'b0)
    hot_reset();
    unlock <= 1'b0;
    rd_chk(ADDR_ERR_CTL, 32'h0000_01E0);
    rd_chk(ADDR_COR_MASK, 32'h0000_31C1);
    wr32(ADDR_ERR_CTL, 32'h0000_0000);
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A0);
    be <= 4'h2;
    wr32(ADDR_ERR_CTL, 32'h0000_01FF);
    be <= 4'hF;
    rd_chk(ADDR_ERR_CTL, 32'h0000_01A0);
    `CHK(chk_en, 1'b1)
    `CHK(gen_en, 1'b0)
    wr32(ADDR_ERR_CTL, 32'h0000_0000);
    $display("test control_fields done");

    sbe_en <= 1'b1;
    wr32(ADDR_COR_MASK, 32'h0000_0000);
    for (i = 0; i < 7; i++)
    begin
      pulse(7'(1 << i));
      `CHK(rep, 1'b1)
    end
    rd_chk(ADDR_COR_STATUS, COR_IMPL_BITS);
    wr32(ADDR_COR_MASK, COR_IMPL_BITS);
    rd_chk(ADDR_COR_MASK, COR_IMPL_BITS);
    wr32(ADDR_COR_STATUS, COR_IMPL_BITS);
    rd_chk(ADDR_COR_STATUS, 32'h0000_0000);
    for (i = 0; i < 7; i++)
    begin
      pulse(7'(1 << i));
      `CHK(rep, 1'b0)
    end
    rd_chk(ADDR_COR_STATUS, COR_IMPL_BITS);
    `CHK(n_rep, 16'd7)
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A0);
    sbe_en <= 1'b0;
    rd_chk(ADDR_COR_MASK, 32'h0000_31C1);
    rd_chk(ADDR_COR_STATUS, 32'h0000_31C1);
    $display("test events done");

    `CHK(irq, 1'b0)
    wr32(ADDR_IRQ_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, 1'b1)
    wr32(ADDR_IRQ_STATUS, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, 1'b0)
    rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000);
    $display("test interrupt done");

    unc(5'd5, HDR_A);
    unc(5'd9, ~HDR_A);
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A5);
    for (i = 0; i < HDR_WORDS; i++)
      rd_chk(ADDR_HDR_LOG0 + 12'(4 * i), HDR_A[32 * i +: 32]);
    rd_chk(ADDR_IRQ_STATUS, 32'h0000_0002);
    hot_reset();
    rd_chk(ADDR_HDR_LOG3, HDR_A[127:96]);
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A5);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    unc(5'd9, ~HDR_A);
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A9);
    rd_chk(ADDR_HDR_LOG1, ~HDR_A[63:32]);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(ADDR_HDR_LOG0, 32'h0000_0000);
    rd_chk(ADDR_ERR_CTL, 32'h0000_00A0);
    $display("test header_capture done");
    end_of_test();
  end
endmodule
